// ==== hw/uft_pkg.sv ====
// Constants for the frame timer and interrupt status block
package uft_pkg;
    // Register offsets on the 8-bit parallel bus
    localparam logic [7:0] OFS_FLAGS = 8'h0d;
    localparam logic [7:0] OFS_REV_LOW = 8'h0e;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h0f;
    // Status bit positions
    localparam int BIT_DPLUS = 7;
    localparam int BIT_DETECT = 6;
    localparam int BIT_INSREM = 5;
    localparam int BIT_SOF = 4;
    localparam int BIT_DONE_B = 1;
    localparam int BIT_DONE_A = 0;
    // Revision field and reserved bits on read of the revision register
    localparam int REV_LSB = 4;
    localparam logic [3:0] REV_LOW_BITS = 4'h0;
    // Interval counter layout
    localparam int COUNT_W = 14;
    localparam int HIGH_W = 6;
    localparam int READ_LSB = 6;
    localparam int FRAME_W = 11;
    // Reset values
    localparam logic [COUNT_W-1:0] RELOAD_RST = 14'h0000;
    localparam logic [FRAME_W-1:0] FRAME_RST = 11'h000;
    localparam logic SE0_RST = 1'b1;
    localparam logic [7:0] RDATA_RST = 8'h00;
    // Rates: system clock and the internal full-speed bit tick
    localparam int SYS_KHZ = 25000;
    localparam int TICK_KHZ = 12000;
    localparam int ACC_W = 16;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICK_KHZ / 1000);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_KHZ / 1000);
    localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;
endpackage

// ==== hw/uft_flag.sv ====
// One sticky status flag: hardware set, write-one clear
`timescale 1ns/10ps
`default_nettype none
module uft_flag (
    input wire logic clk,
    input wire logic srst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic next_q;

    // Set beats clear in the same cycle
    always_comb begin
        next_q = q;
        if (clr) begin
            next_q = 1'b0;
        end
        if (set) begin
            next_q = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end
endmodule // uft_flag
`default_nettype wire

// ==== hw/uft_core.sv ====
// Interrupt status, revision readback and start-of-frame interval timer
`timescale 1ns/10ps
`default_nettype none
module uft_core #(
    parameter logic [3:0] REVISION = 4'h7 // Arbitrary value
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic resume_mode,
    input wire logic sof_enable,
    input wire logic host_mode,
    input wire logic [7:0] irq_enable,
    input wire logic dplus_level,
    input wire logic line_se0,
    input wire logic resume_event,
    input wire logic done_a,
    input wire logic done_b,
    output logic irq_out,
    output logic sof_send,
    output logic [uft_pkg::FRAME_W-1:0] frame_number
);
    localparam int CW = uft_pkg::COUNT_W;
    logic [uft_pkg::ACC_W-1:0] acc, next_acc;
    logic tick12;
    logic [CW-1:0] reload, next_reload;
    logic [CW-1:0] count, next_count;
    logic [uft_pkg::FRAME_W-1:0] next_frame_number;
    logic next_sof_send;
    logic prev_se0, next_prev_se0;
    logic [7:0] next_rdata;
    logic [7:0] status;
    logic [4:0] flag_set, flag_clr, flag_q;
    logic wr_flags, wr_low, wr_high;

    assign wr_flags = wr_en && (addr == uft_pkg::OFS_FLAGS);
    assign wr_low = wr_en && (addr == uft_pkg::OFS_REV_LOW);
    assign wr_high = wr_en && (addr == uft_pkg::OFS_COUNT_HIGH);

    // Sticky flags: 4 resume, 3 insert/remove, 2 sof, 1 done B, 0 done A
    assign flag_set = {resume_mode && resume_event,
                       host_mode && (prev_se0 != line_se0),
                       next_sof_send,
                       done_b, done_a};
    assign flag_clr = {wdata[uft_pkg::BIT_DETECT], wdata[uft_pkg::BIT_INSREM],
                       wdata[uft_pkg::BIT_SOF], wdata[uft_pkg::BIT_DONE_B],
                       wdata[uft_pkg::BIT_DONE_A]} & {5{wr_flags}};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            uft_flag u_flag (
                .clk(clk),
                .srst(srst),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .q(flag_q[gi])
            );
        end
    endgenerate

    // Status view: live D+, shared bit 6, reserved bits zero
    always_comb begin
        status = 8'h00;
        status[uft_pkg::BIT_DPLUS] = dplus_level;
        status[uft_pkg::BIT_DETECT] = resume_mode ? flag_q[4] : line_se0;
        status[uft_pkg::BIT_INSREM] = flag_q[3];
        status[uft_pkg::BIT_SOF] = flag_q[2];
        status[uft_pkg::BIT_DONE_B] = flag_q[1];
        status[uft_pkg::BIT_DONE_A] = flag_q[0];
    end

    // Level interrupt; enables only gate the pin
    assign irq_out = |(status & irq_enable & 8'h7f);

    // Fractional divider gives a 12 MHz tick from the system clock
    always_comb begin
        next_acc = acc + uft_pkg::ACC_STEP;
        tick12 = 1'b0;
        if (next_acc >= uft_pkg::ACC_MOD) begin
            next_acc = next_acc - uft_pkg::ACC_MOD;
            tick12 = 1'b1;
        end
    end

    // Reload value, down counter, frame number, read data
    always_comb begin
        next_reload = reload;
        if (wr_low) begin
            next_reload[7:0] = wdata;
        end
        if (wr_high) begin
            next_reload[CW-1:8] = wdata[uft_pkg::HIGH_W-1:0];
        end
        next_count = count;
        next_sof_send = 1'b0;
        if (!sof_enable) begin
            next_count = reload;
        end else if (tick12) begin
            // Reload on the tick that reaches zero, so a frame lasts reload ticks, or one tick when reload is zero
            if (count < 14'h0002) begin
                next_count = reload;
                next_sof_send = 1'b1;
            end else begin
                next_count = count - 1'b1;
            end
        end
        next_frame_number = frame_number;
        if (next_sof_send) begin
            next_frame_number = frame_number + 1'b1;
        end
        if (wr_high) begin
            next_frame_number = uft_pkg::FRAME_RST;
        end
        next_prev_se0 = line_se0;
        next_rdata = rdata;
        if (rd_en) begin
            case (addr)
                uft_pkg::OFS_FLAGS: next_rdata = status;
                uft_pkg::OFS_REV_LOW: next_rdata = {REVISION, uft_pkg::REV_LOW_BITS};
                uft_pkg::OFS_COUNT_HIGH: next_rdata = count[CW-1:uft_pkg::READ_LSB];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register all state but the sticky flags
    always_ff @(posedge clk) begin
        if (srst) begin
            acc <= uft_pkg::ACC_RST;
            reload <= uft_pkg::RELOAD_RST;
            count <= uft_pkg::RELOAD_RST;
            frame_number <= uft_pkg::FRAME_RST;
            sof_send <= 1'b0;
            prev_se0 <= uft_pkg::SE0_RST;
            rdata <= uft_pkg::RDATA_RST;
        end else begin
            acc <= next_acc;
            reload <= next_reload;
            count <= next_count;
            frame_number <= next_frame_number;
            sof_send <= next_sof_send;
            prev_se0 <= next_prev_se0;
            rdata <= next_rdata;
        end
    end

    // Checks on the registered behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_dplus; rd_en && addr == 8'h0d |=> rdata[7] == $past(dplus_level); endproperty
    a_dplus: assert property (p_dplus) else $error("D+ bit wrong");
    property p_resume; resume_mode && resume_event |=> flag_q[4]; endproperty
    a_resume: assert property (p_resume) else $error("Resume flag not set");
    property p_present;
        rd_en && addr == 8'h0d && !resume_mode |=> rdata[6] == $past(line_se0);
    endproperty
    a_present: assert property (p_present) else $error("Presence bit wrong");
    property p_insrem; host_mode && (line_se0 != $past(line_se0)) |=> flag_q[3]; endproperty
    a_insrem: assert property (p_insrem) else $error("Insert flag not set");
    property p_sof_flag; sof_send |-> flag_q[2]; endproperty
    a_sof_flag: assert property (p_sof_flag) else $error("SOF flag not set");
    property p_done; done_a && done_b |=> flag_q[1] && flag_q[0]; endproperty
    a_done: assert property (p_done) else $error("Done flags not set");
    property p_rev; rd_en && addr == 8'h0e |=> rdata == {REVISION, 4'h0}; endproperty
    a_rev: assert property (p_rev) else $error("Revision read wrong");
    property p_low; wr_en && addr == 8'h0e |=> reload[7:0] == $past(wdata); endproperty
    a_low: assert property (p_low) else $error("Low reload not loaded");
    property p_high; wr_en && addr == 8'h0f |=> reload[13:8] == $past(wdata[5:0]); endproperty
    a_high: assert property (p_high) else $error("High reload not loaded");
    property p_tick; tick12 |=> !tick12; endproperty
    a_tick: assert property (p_tick) else $error("Tick rate too high");
    property p_read; rd_en && addr == 8'h0f |=> rdata == $past(count[13:6]); endproperty
    a_read: assert property (p_read) else $error("Count readback wrong");
    property p_down;
        sof_enable && tick12 && count > 14'h0001 |=> count == $past(count) - 14'h0001;
    endproperty
    a_down: assert property (p_down) else $error("Count not decremented");
    property p_clr_frame; wr_en && addr == 8'h0f |=> frame_number == 11'h000; endproperty
    a_clr_frame: assert property (p_clr_frame) else $error("Frame not cleared");
    property p_frame;
        sof_send && !$past(wr_high) |-> frame_number == $past(frame_number) + 11'h001;
    endproperty
    a_frame: assert property (p_frame) else $error("Frame not advanced");
    property p_reload;
        sof_send |-> count == $past(reload) && $past(count) < 14'h0002;
    endproperty
    a_reload: assert property (p_reload) else $error("Reload at zero wrong");
    property p_clear;
        wr_en && addr == 8'h0d && wdata[0] && !done_a |=> !flag_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("Flag not cleared");
    property p_irq; (flag_q[2] && irq_enable[4]) |-> irq_out; endproperty
    a_irq: assert property (p_irq) else $error("Irq not asserted");
endmodule // uft_core
`default_nettype wire

// ==== verif/uft_cpu_model.sv ====
// Bus master model of the external microprocessor on the 8-bit port
`timescale 1ns/10ps
`default_nettype none
module uft_cpu_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [7:0] rdata
);
    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // One write; address and data scrambled once released
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // One read; data taken after the registered answer lands
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rdata;
    endtask
endmodule // uft_cpu_model
`default_nettype wire

// ==== verif/uft_core_tb.sv ====
// Self-checking testbench of the frame timer and status block
`timescale 1ns/10ps
`default_nettype none
module uft_core_tb;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    logic clk = 1'b0, srst = 1'b1, resume_mode = 1'b1, sof_enable = 1'b0, host_mode = 1'b1;
    logic [7:0] irq_enable = 8'h00, addr, wdata, rdata, d, expf;
    logic dplus_level = 1'b0, line_se0 = 1'b1, resume_event = 1'b0, done_a = 1'b0, done_b = 1'b0;
    logic wr_en, rd_en, irq_out, sof_send;
    logic [10:0] frame_number;
    logic [31:0] seed = 32'd95975;
    int mismatches = 0, check_count = 0, c;
    // Clock of 40 ns
    always #20 clk = ~clk;
    uft_core #(.REVISION(REV)) u_uft_core (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .resume_mode(resume_mode),
        .sof_enable(sof_enable), .host_mode(host_mode), .irq_enable(irq_enable),
        .dplus_level(dplus_level), .line_se0(line_se0), .resume_event(resume_event),
        .done_a(done_a), .done_b(done_b), .irq_out(irq_out), .sof_send(sof_send),
        .frame_number(frame_number));
    uft_cpu_model u_uft_cpu_model (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));
    // Pseudo-random sequence
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Common compare
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One-cycle event pulses {resume, b, a}
    task automatic pulse_events(input logic [2:0] ev);
        @(posedge clk);
        {resume_event, done_b, done_a} <= ev;
        @(posedge clk);
        {resume_event, done_b, done_a} <= 3'b000;
    endtask
    // Bounded wait for the next frame pulse
    task automatic wait_sof(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sof_send !== 1'b1 && n < 26000);
        if (sof_send !== 1'b1) begin
            mismatches++;
            $display("BAD sof_send timeout");
            finish_test();
        end
    endtask
    // Program reload, run two frames, measure spacing in clocks
    task automatic frame_test(input logic [7:0] lo, input logic [7:0] hi, input int ticks);
        @(posedge clk);
        sof_enable <= 1'b0;
        u_uft_cpu_model.write_reg(uft_pkg::OFS_REV_LOW, lo);
        u_uft_cpu_model.write_reg(uft_pkg::OFS_COUNT_HIGH, hi);
        @(posedge clk);
        check("frame_cleared", 16'h0000, 16'(frame_number));
        sof_enable <= 1'b1;
        wait_sof(c);
        check("frame_one", 16'h0001, 16'(frame_number));
        wait_sof(c);
        check("frame_two", 16'h0002, 16'(frame_number));
        check("period_min", 16'h0001, 16'(c >= ticks * 25 / 12));
        check("period_max", 16'h0001, 16'(c <= (ticks * 25 + 11) / 12));
        u_uft_cpu_model.read_reg(uft_pkg::OFS_COUNT_HIGH, d);
        check("count_high", 16'((ticks - 1) >> 6), 16'(d));
        u_uft_cpu_model.read_reg(uft_pkg::OFS_FLAGS, d);
        check("sof_flag", 16'h0001, 16'(d[uft_pkg::BIT_SOF]));
        u_uft_cpu_model.write_reg(uft_pkg::OFS_FLAGS, 8'h10);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        u_uft_cpu_model.read_reg(uft_pkg::OFS_REV_LOW, d);
        check("revision", 16'({REV, 4'h0}), 16'(d));
        u_uft_cpu_model.read_reg(8'h05, d);
        check("unmapped", 16'h0000, 16'(d));
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            @(posedge clk);
            irq_enable <= seed[7:0];
            dplus_level <= seed[8];
            pulse_events(seed[11:9]);
            expf = {seed[8], seed[11], 4'h0, seed[10], seed[9]};
            u_uft_cpu_model.read_reg(uft_pkg::OFS_FLAGS, d);
            check("flags", 16'(expf), 16'(d));
            check("irq", 16'(|(expf[6:0] & seed[6:0])), 16'(irq_out));
            u_uft_cpu_model.write_reg(uft_pkg::OFS_FLAGS, seed[23:16]);
            u_uft_cpu_model.read_reg(uft_pkg::OFS_FLAGS, d);
            check("flags_clear", 16'({expf[7], expf[6:0] & ~seed[22:16]}), 16'(d));
            u_uft_cpu_model.write_reg(uft_pkg::OFS_FLAGS, 8'hff);
        end
        @(posedge clk);
        resume_mode <= 1'b0;
        line_se0 <= 1'b0;
        u_uft_cpu_model.read_reg(uft_pkg::OFS_FLAGS, d);
        check("insert", 16'({dplus_level, 7'h20}), 16'(d));
        u_uft_cpu_model.write_reg(uft_pkg::OFS_FLAGS, 8'h20);
        host_mode <= 1'b0;
        line_se0 <= 1'b1;
        u_uft_cpu_model.read_reg(uft_pkg::OFS_FLAGS, d);
        check("no_host", 16'({dplus_level, 7'h40}), 16'(d));
        frame_test(8'h00, 8'h00, 1);
        frame_test(8'he0, 8'hae, 12000);
        finish_test();
    end
endmodule // uft_core_tb
`default_nettype wire
